// ---- hw/ocf_clk_ctrl.sv ----
// Purpose: composite clock, line rate clock and 8k/2k sync outputs
// Assumes: synthesis ticks from both paths, pulse width reference on pclk
// Notes:   APB slave with zero wait states once ce is high
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "ocf_params.svh"
module ocf_clk_ctrl #(
  parameter int NCO_W = `OCF_NCO_W
) (
  input  wire logic              pclk,                      // system clock
  input  wire logic              presetn,                   // async reset, low
  input  wire logic              ce,                        // clock enable
  input  wire logic              psel,                      // apb select
  input  wire logic              penable,                   // apb access phase
  input  wire logic              pwrite,                    // apb write
  input  wire ocf_pkg::ocf_addr_t paddr,                    // apb byte address
  input  wire ocf_pkg::ocf_word_t pwdata,                   // apb write data
  output ocf_pkg::ocf_word_t     prdata,                    // apb read data
  output logic                   pready,                    // apb ready
  output logic                   pslverr,                   // apb error
  input  wire logic              main_syn_tick,             // main path synthesis tick
  input  wire logic              aux_syn_tick,              // aux path synthesis tick
  input  wire logic              aux_ref_valid,             // aux path has valid reference
  input  wire logic              pulse_width_ref_output,    // pulse width reference clock
  output logic                   composite_clock_output,    // 64k composite clock
  output logic                   composite_clock_output_oe, // composite driven
  output logic                   line_rate_output,          // DS1/E1 clock
  output logic                   line_rate_output_oe,       // line rate driven
  output logic                   sync8k_output,             // 8k clock or frame sync
  output logic                   sync8k_output_oe,          // 8k driven
  output logic                   sync2k_output,             // 2k clock or frame sync
  output logic                   sync2k_output_oe           // 2k driven
);
  import ocf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  localparam logic [7:0] CC_HALF = 8'(`OCF_CC_DIV / 2 - 1);
  localparam logic [NCO_W-1:0] INC_DS1 =
    NCO_W'((64'(`OCF_DS1_KHZ) << NCO_W) / `OCF_SYN_KHZ);
  localparam logic [NCO_W-1:0] INC_E1 =
    NCO_W'((64'(`OCF_E1_KHZ) << NCO_W) / `OCF_SYN_KHZ);

  typedef struct packed {
    ocf_cfg_t  mcfg3;
    ocf_cfg_t  mcfg4;
    ocf_cfg_t  auxcfg1;
    ocf_cfg_t  outcfg4;
    ocf_cfg_t  fscfg1;
    ocf_word_t rdata;
    logic      rd_vld;
    logic [7:0] cc_cnt;
    logic      cc_lvl;
    logic      pwr_q;
    logic      cc_out;
    logic      cc_oe;
    logic      line_out;
    logic      line_oe;
  } ocf_st_t;

  ocf_st_t          st_ff;
  ocf_st_t          nxt_st;
  logic             pair_source_select;
  logic             aux_auto_squelch;
  logic             line_rate_out_enable;
  logic             aux_line_rate_select;
  logic             main_line_rate_select;
  logic             squelch;
  logic             src_tick;
  logic             rate_e1;
  logic [NCO_W-1:0] nco_inc;
  logic             nco_lvl;
  logic             wr_en;
  logic             mapped;

  ocf_fs_if fs8k ();
  ocf_fs_if fs2k ();

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic ocf_is_mapped(input ocf_addr_t a);
    unique case (a)
      `OCF_OFS_MCFG3, `OCF_OFS_MCFG4, `OCF_OFS_AUXCFG1,
      `OCF_OFS_OUTCFG4, `OCF_OFS_FSCFG1, `OCF_OFS_STATUS: ocf_is_mapped = 1'b1;
      default: ocf_is_mapped = 1'b0;
    endcase
  endfunction : ocf_is_mapped

  // config fields used by the output logic
  assign pair_source_select    = st_ff.mcfg4[`OCF_B_PAIR_SRC];
  assign aux_auto_squelch      = st_ff.auxcfg1[`OCF_B_AUX_SQL];
  assign aux_line_rate_select  = st_ff.auxcfg1[`OCF_B_AUX_RATE];
  assign main_line_rate_select = st_ff.mcfg3[`OCF_B_MAIN_RATE];
  assign line_rate_out_enable  = st_ff.outcfg4[`OCF_B_LINE_EN];

  // apb handshake, ready only after read data was captured under ce
  assign mapped  = ocf_is_mapped(paddr);
  assign pready  = ce & st_ff.rd_vld;
  assign pslverr = pready & ~mapped;
  assign wr_en   = psel & penable & pready & pwrite & mapped;
  assign prdata  = st_ff.rdata;

  // ****************************************************************
  // source selection and squelch
  // ****************************************************************
  assign src_tick = pair_source_select ? main_syn_tick : aux_syn_tick;
  // squelch only ever applies while the pair follows the aux path
  assign squelch = ~pair_source_select & aux_auto_squelch & ~aux_ref_valid;
  assign rate_e1 = pair_source_select ? main_line_rate_select : aux_line_rate_select;
  assign nco_inc = rate_e1 ? INC_E1 : INC_DS1;

  ocf_nco #(
    .W (NCO_W)
  ) u_nco (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .tick    (src_tick),
    .inc     (nco_inc),
    .level   (nco_lvl)
  );

  // ****************************************************************
  // frame sync generators, both on the main path
  // ****************************************************************
  assign fs8k.tick       = main_syn_tick;
  assign fs8k.pwr_rise   = pulse_width_ref_output & ~st_ff.pwr_q;
  assign fs8k.en         = st_ff.outcfg4[`OCF_B_S8K_EN];
  assign fs8k.pulse_mode = st_ff.fscfg1[`OCF_B_S8K_PUL];
  assign fs8k.invert     = st_ff.fscfg1[`OCF_B_S8K_INV];
  assign fs2k.tick       = main_syn_tick;
  assign fs2k.pwr_rise   = pulse_width_ref_output & ~st_ff.pwr_q;
  assign fs2k.en         = st_ff.outcfg4[`OCF_B_S2K_EN];
  assign fs2k.pulse_mode = st_ff.fscfg1[`OCF_B_S2K_PUL];
  assign fs2k.invert     = st_ff.fscfg1[`OCF_B_S2K_INV];

  ocf_fsync_gen #(
    .FRAME_TICKS (`OCF_FR8K_TICKS)
  ) u_sync8k (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .fs      (fs8k.gen)
  );

  ocf_fsync_gen #(
    .FRAME_TICKS (`OCF_FR2K_TICKS)
  ) u_sync2k (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .fs      (fs2k.gen)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pwr_q = pulse_width_ref_output;
    // register writes
    if (wr_en) begin
      unique case (paddr)
        `OCF_OFS_MCFG3:   nxt_st.mcfg3   = pwdata[7:0];
        `OCF_OFS_MCFG4:   nxt_st.mcfg4   = pwdata[7:0];
        `OCF_OFS_AUXCFG1: nxt_st.auxcfg1 = pwdata[7:0];
        `OCF_OFS_OUTCFG4: nxt_st.outcfg4 = pwdata[7:0];
        `OCF_OFS_FSCFG1:  nxt_st.fscfg1  = pwdata[7:0];
        default: begin
        end
      endcase
    end
    // read capture, status shows live output state
    nxt_st.rd_vld = psel & ~(penable & pready);
    nxt_st.rdata  = 32'h0000_0000;
    unique case (paddr)
      `OCF_OFS_MCFG3:   nxt_st.rdata[7:0] = st_ff.mcfg3;
      `OCF_OFS_MCFG4:   nxt_st.rdata[7:0] = st_ff.mcfg4;
      `OCF_OFS_AUXCFG1: nxt_st.rdata[7:0] = st_ff.auxcfg1;
      `OCF_OFS_OUTCFG4: nxt_st.rdata[7:0] = st_ff.outcfg4;
      `OCF_OFS_FSCFG1:  nxt_st.rdata[7:0] = st_ff.fscfg1;
      `OCF_OFS_STATUS:  nxt_st.rdata[7:0] = {2'b00, st_ff.cc_out, st_ff.line_out,
                                             fs8k.out, fs2k.out, aux_ref_valid, squelch};
      default: begin
      end
    endcase
    // composite clock: fixed divide of the source tick, no rate setting
    if (src_tick) begin
      if (st_ff.cc_cnt == CC_HALF) begin
        nxt_st.cc_cnt = 8'h00;
        nxt_st.cc_lvl = ~st_ff.cc_lvl;
      end else begin
        nxt_st.cc_cnt = st_ff.cc_cnt + 8'h01;
      end
    end
    nxt_st.cc_out   = st_ff.cc_lvl & ~squelch;
    nxt_st.cc_oe    = ~squelch;
    nxt_st.line_out = nco_lvl & line_rate_out_enable & ~squelch;
    nxt_st.line_oe  = line_rate_out_enable & ~squelch;
  end

  // all state frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.mcfg3   <= `OCF_RST_CFG;
      st_ff.mcfg4   <= `OCF_RST_CFG;
      st_ff.auxcfg1 <= `OCF_RST_CFG;
      st_ff.outcfg4 <= `OCF_RST_CFG;
      st_ff.fscfg1  <= `OCF_RST_CFG;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign composite_clock_output    = st_ff.cc_out;
  assign composite_clock_output_oe = st_ff.cc_oe;
  assign line_rate_output          = st_ff.line_out;
  assign line_rate_output_oe       = st_ff.line_oe;
  assign sync8k_output             = fs8k.out;
  assign sync8k_output_oe          = fs8k.oe;
  assign sync2k_output             = fs2k.out;
  assign sync2k_output_oe          = fs2k.oe;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_src_main : assert property (@(posedge pclk) disable iff (!presetn)
    pair_source_select |-> (src_tick == main_syn_tick))
    else $error("pair not following main path");
  a_src_aux : assert property (@(posedge pclk) disable iff (!presetn)
    !pair_source_select |-> (src_tick == aux_syn_tick))
    else $error("pair not following aux path");
  a_squelch_both : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !pair_source_select && aux_auto_squelch && !aux_ref_valid)
    |=> (!composite_clock_output_oe && !line_rate_output_oe))
    else $error("pair not squelched without aux reference");
  a_cc_toggle : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && src_tick && st_ff.cc_cnt == CC_HALF) |=> (st_ff.cc_lvl != $past(st_ff.cc_lvl)))
    else $error("composite clock missed its toggle");
  a_cc_hold : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !(src_tick && st_ff.cc_cnt == CC_HALF)) |=> $stable(st_ff.cc_lvl))
    else $error("composite clock toggled early");
  a_line_off : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !line_rate_out_enable) |=> (!line_rate_output_oe && !line_rate_output))
    else $error("line rate output driven while disabled");
  a_rate_pick : assert property (@(posedge pclk) disable iff (!presetn)
    (nco_inc == INC_E1) == (pair_source_select ? main_line_rate_select : aux_line_rate_select))
    else $error("wrong DS1/E1 rate source");
  a_apb_zero : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable) ##1 (ce && psel && penable) |-> pready)
    else $error("apb access not ready after setup");

  // main sourced pair never squelches, whatever the aux reference does
  a_cc_main_on : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pair_source_select) |=> composite_clock_output_oe)
    else $error("pair squelched while on main path");
  // without auto squelch a lost aux reference leaves the pair running
  a_no_auto_sql : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !aux_auto_squelch) |=> composite_clock_output_oe)
    else $error("pair squelched with auto squelch off");
  // an enabled, unsquelched line output must be driven
  a_line_on : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && line_rate_out_enable && !squelch) |=> line_rate_output_oe)
    else $error("line rate output not driven while enabled");
  // a refused write must not disturb the output control word
  a_wr_refused : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && penable && pready && !mapped) |=> $stable(st_ff.outcfg4))
    else $error("unmapped write changed a register");

  c_squelch : cover property (@(posedge pclk) disable iff (!presetn) squelch && ce);
  c_main_e1 : cover property (@(posedge pclk) disable iff (!presetn)
    pair_source_select && main_line_rate_select && line_rate_output_oe);
  c_wr : cover property (@(posedge pclk) disable iff (!presetn) wr_en);
endmodule : ocf_clk_ctrl
`default_nettype wire

// ---- hw/ocf_params.svh ----
// Purpose: constants of the output clock and frame sync control block
// Assumes: pclk at 200 MHz, path synthesis ticks at OCF_SYN_KHZ
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef OCF_PARAMS_SVH
`define OCF_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OCF_OFS_MCFG3     12'h000
`define OCF_OFS_MCFG4     12'h004
`define OCF_OFS_AUXCFG1   12'h008
`define OCF_OFS_OUTCFG4   12'h00c
`define OCF_OFS_FSCFG1    12'h010
`define OCF_OFS_STATUS    12'h014

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define OCF_B_MAIN_RATE   0
`define OCF_B_PAIR_SRC    0
`define OCF_B_AUX_SQL     0
`define OCF_B_AUX_RATE    1
`define OCF_B_LINE_EN     0
`define OCF_B_S8K_EN      1
`define OCF_B_S2K_EN      2
`define OCF_B_S8K_PUL     0
`define OCF_B_S8K_INV     1
`define OCF_B_S2K_PUL     2
`define OCF_B_S2K_INV     3
`define OCF_RST_CFG       8'h00

// ****************************************************************
// timing
// ****************************************************************
`define OCF_SYN_KHZ       4096
`define OCF_CC_KHZ        64
`define OCF_DS1_KHZ       1544
`define OCF_E1_KHZ        2048
`define OCF_FR8K_US       125
`define OCF_FR2K_US       500
`define OCF_CC_DIV        (`OCF_SYN_KHZ / `OCF_CC_KHZ)
`define OCF_FR8K_TICKS    (`OCF_SYN_KHZ * `OCF_FR8K_US / 1000)
`define OCF_FR2K_TICKS    (`OCF_SYN_KHZ * `OCF_FR2K_US / 1000)
`define OCF_NCO_W         24

`endif

// ---- hw/ocf_pkg.sv ----
// Purpose: shared types of the output clock and frame sync control block
// Assumes: nothing beyond the params header
// Notes:   no constants here, they live in ocf_params.svh
package ocf_pkg;
  typedef logic [11:0] ocf_addr_t;
  typedef logic [31:0] ocf_word_t;
  typedef logic [7:0]  ocf_cfg_t;

  // frame pulse phase
  typedef enum logic [1:0] {
    OCF_FS_IDLE  = 2'b00,
    OCF_FS_ARMED = 2'b01,
    OCF_FS_LOW   = 2'b10
  } ocf_fs_state_t;
endpackage : ocf_pkg

// ---- hw/ocf_fs_if.sv ----
// Purpose: control and output bundle of one frame sync generator
// Assumes: all signals on pclk
// Notes:   gen side is the generator, ctl side the control top
`timescale 1ns/100ps
`default_nettype none
interface ocf_fs_if;
  logic tick;       // main path synthesis tick
  logic pwr_rise;   // rising edge of pulse width reference
  logic en;         // output enable bit
  logic pulse_mode; // frame pulse instead of square wave
  logic invert;     // polarity invert
  logic out;        // output level
  logic oe;         // output driven
  modport gen (input tick, pwr_rise, en, pulse_mode, invert, output out, oe);
  modport ctl (output tick, pwr_rise, en, pulse_mode, invert, input out, oe);
endinterface : ocf_fs_if
`default_nettype wire

// ---- hw/ocf_nco.sv ----
// Purpose: phase accumulator synthesis of the line rate clock
// Assumes: tick is a one-cycle strobe from the selected path
// Notes:   output is the accumulator top bit, jitter one tick
`timescale 1ns/100ps
`default_nettype none
`include "ocf_params.svh"
module ocf_nco #(
  parameter int W = `OCF_NCO_W
) (
  input  wire logic         pclk,    // system clock
  input  wire logic         presetn, // async reset, low
  input  wire logic         ce,      // clock enable
  input  wire logic         tick,    // synthesis tick
  input  wire logic [W-1:0] inc,     // phase step per tick
  output logic              level    // synthesized clock
);
  import ocf_pkg::*;

  typedef struct packed {
    logic [W-1:0] acc;
  } ocf_nco_st_t;

  ocf_nco_st_t st_ff;
  ocf_nco_st_t nxt_st;

  // accumulate on each tick, wrap is free
  always_comb begin
    nxt_st = st_ff;
    if (tick) begin
      nxt_st.acc = st_ff.acc + inc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.acc[W-1];

  a_nco_step : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && tick) |=> st_ff.acc == W'($past(st_ff.acc) + $past(inc)))
    else $error("nco did not advance by its step");
endmodule : ocf_nco
`default_nettype wire

// ---- hw/ocf_fsync_gen.sv ----
// Purpose: 8k or 2k square wave or frame pulse from the main path
// Assumes: pulse width reference runs well above the frame rate
// Notes:   pulse waits for the next reference rise, so it lags the frame edge
`timescale 1ns/100ps
`default_nettype none
`include "ocf_params.svh"
module ocf_fsync_gen #(
  parameter int FRAME_TICKS = `OCF_FR8K_TICKS
) (
  input  wire logic pclk,    // system clock
  input  wire logic presetn, // async reset, low
  input  wire logic ce,      // clock enable
  ocf_fs_if.gen     fs       // control and output bundle
);
  import ocf_pkg::*;

  typedef struct packed {
    logic [11:0]   cnt;
    ocf_fs_state_t ph;
    logic          out;
    logic          oe;
  } ocf_fs_st_t;

  localparam logic [11:0] LAST = 12'(FRAME_TICKS - 1);
  localparam logic [11:0] HALF = 12'(FRAME_TICKS / 2);

  ocf_fs_st_t st_ff;
  ocf_fs_st_t nxt_st;
  logic       raw;

  // frame counter, pulse phase and output shaping
  always_comb begin
    nxt_st = st_ff;
    raw    = 1'b0;
    if (fs.tick) begin
      nxt_st.cnt = (st_ff.cnt == LAST) ? 12'h000 : st_ff.cnt + 12'h001;
    end
    unique case (st_ff.ph)
      OCF_FS_IDLE: begin
        if (fs.tick && st_ff.cnt == LAST) begin
          nxt_st.ph = OCF_FS_ARMED;
        end
      end
      OCF_FS_ARMED: begin
        if (fs.pwr_rise) begin
          nxt_st.ph = OCF_FS_LOW;
        end
      end
      OCF_FS_LOW: begin
        if (fs.pwr_rise) begin
          nxt_st.ph = OCF_FS_IDLE;
        end
      end
      default: begin
        nxt_st.ph = OCF_FS_IDLE;
      end
    endcase
    if (!fs.pulse_mode) begin
      nxt_st.ph = OCF_FS_IDLE;
    end
    // square wave high first half of the frame, low second half; frame pulse low in OCF_FS_LOW
    if (fs.pulse_mode) begin
      raw = (nxt_st.ph != OCF_FS_LOW);
    end else begin
      raw = (nxt_st.cnt < HALF);
    end
    nxt_st.out = fs.en & (raw ^ fs.invert);
    nxt_st.oe  = fs.en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign fs.out = st_ff.out;
  assign fs.oe  = st_ff.oe;

  a_sync_off : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !fs.en) |=> (!fs.oe && !fs.out))
    else $error("sync output driven while disabled");
  a_clk_half : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fs.en && !fs.pulse_mode && !fs.invert && !fs.tick && st_ff.cnt == HALF)
    |=> !fs.out)
    else $error("square wave not low in second half");
  a_pulse_end : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fs.pulse_mode && st_ff.ph == OCF_FS_LOW && fs.pwr_rise) |=> st_ff.ph == OCF_FS_IDLE)
    else $error("frame pulse longer than one reference period");
  a_pulse_align : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && $rose(st_ff.ph == OCF_FS_LOW)) |-> $past(fs.pwr_rise))
    else $error("frame pulse not aligned to reference rise");
  a_pulse_pol : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fs.en && fs.pulse_mode && !fs.tick && st_ff.ph == OCF_FS_IDLE && !fs.pwr_rise)
    |=> fs.out == !fs.invert)
    else $error("frame sync idle level wrong");
  c_pulse : cover property (@(posedge pclk) disable iff (!presetn)
    fs.en && fs.pulse_mode && st_ff.ph == OCF_FS_LOW);
endmodule : ocf_fsync_gen
`default_nettype wire

// ---- testbench/ocf_timing_src.sv ----
// Purpose: path ticks and pulse width reference feeding the block
// Assumes: a tick every 2 pclk stands for the 4096kHz main rate
// Notes:   reference period 4 pclk, well above 1.544MHz scaled to ticks
`timescale 1ns/100ps
`default_nettype none
module ocf_timing_src #(
  parameter int MAIN_DIV = 2, // pclk per main tick
  parameter int AUX_DIV  = 3, // pclk per aux tick
  parameter int REF_PER  = 4  // pclk per reference period
) (
  input  wire logic pclk,                  // system clock
  input  wire logic presetn,               // async reset, low
  output logic      main_syn_tick,         // main tick strobe
  output logic      aux_syn_tick,          // aux tick strobe
  output logic      pulse_width_ref_output // reference clock
);
  int m_ff, a_ff, r_ff;
  // free running dividers, never paused so windows hold whole periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ff <= 0;
      a_ff <= 0;
      r_ff <= 0;
    end else begin
      m_ff <= (m_ff + 1) % MAIN_DIV;
      a_ff <= (a_ff + 1) % AUX_DIV;
      r_ff <= (r_ff + 1) % REF_PER;
    end
  end
  assign main_syn_tick = (m_ff == MAIN_DIV - 1);
  assign aux_syn_tick  = (a_ff == AUX_DIV - 1);
  // fast reference from the main side, slower would malform pulses
  assign pulse_width_ref_output = (r_ff < REF_PER / 2);
endmodule : ocf_timing_src
`default_nettype wire

// ---- testbench/tb_ocf_clk_ctrl.sv ----
// Purpose: bench for the output clock and frame sync control block
// Assumes: ticks from ocf_timing_src, ce held high
// Notes:   outputs measured over windows of whole periods
`timescale 1ns/100ps
`default_nettype none
`include "ocf_params.svh"
module tb_ocf_clk_ctrl;
  import ocf_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  ocf_addr_t  paddr;
  ocf_word_t  pwdata, prdata, q;
  logic       mtick, atick, pwr, aref, err;
  logic [3:0] o, oe;
  int         fails, samples_checked, hi, rs, fr;
  ocf_clk_ctrl dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_syn_tick(mtick), .aux_syn_tick(atick), .aux_ref_valid(aref), .pulse_width_ref_output(pwr),
    .composite_clock_output(o[0]), .composite_clock_output_oe(oe[0]), .line_rate_output(o[1]),
    .line_rate_output_oe(oe[1]), .sync8k_output(o[2]), .sync8k_output_oe(oe[2]),
    .sync2k_output(o[3]), .sync2k_output_oe(oe[3]));
  ocf_timing_src src (.pclk(pclk), .presetn(presetn), .main_syn_tick(mtick), .aux_syn_tick(atick),
    .pulse_width_ref_output(pwr));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input ocf_word_t exp, input ocf_word_t got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int up, input int got);
    samples_checked++;
    if (got < lo || got > up) begin
      fails++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, up, got);
    end
  endtask : chk_rng
  // one transfer; entered just after an edge, request held until pready
  task automatic apb(input logic wr, input ocf_addr_t a, input ocf_word_t d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // settle, then count high samples and rising edges of one output
  task automatic meas(input int idx, input int cyc);
    logic p;
    repeat (200) @(posedge pclk);
    p = o[idx];
    hi = 0;
    rs = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (o[idx] === 1'b1) hi++;
      if (o[idx] === 1'b1 && p !== 1'b1) rs++;
      p = o[idx];
    end
  endtask : meas
  task automatic results;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // watchdog, well beyond the roughly 50k cycles the tests need
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    results();
  end
  // ************
  // main sequence
  // ************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    aref = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ocf_addr_t'(4 * i), '0);
      chk("reset value", 32'h0, q);
    end
    apb(1'b0, 12'h018, '0);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, `OCF_OFS_OUTCFG4, 32'h0000_00f1);
    apb(1'b0, `OCF_OFS_OUTCFG4, '0);
    chk("outcfg4 readback", 32'h0000_00f1, q);
    meas(0, 192);
    chk("comp aux high", 32'd96, 32'(hi));
    chk("comp aux rises", 32'd1, 32'(rs));
    meas(1, 12288);
    chk_rng("line ds1 aux", 1543, 1545, rs);
    apb(1'b1, `OCF_OFS_MCFG4, 32'h1);
    meas(0, 128);
    chk("comp main high", 32'd64, 32'(hi));
    apb(1'b1, `OCF_OFS_AUXCFG1, 32'h2);
    meas(1, 8192);
    chk_rng("line ds1 main", 1543, 1545, rs);
    apb(1'b1, `OCF_OFS_MCFG3, 32'h1);
    meas(1, 8192);
    chk_rng("line e1 main", 2047, 2049, rs);
    apb(1'b1, `OCF_OFS_AUXCFG1, 32'h1);
    apb(1'b1, `OCF_OFS_MCFG4, 32'h0);
    aref <= 1'b0;
    meas(0, 192);
    chk("squelch comp", 32'd0, 32'(hi));
    chk("squelch oe", 32'h0, 32'(oe[1:0]));
    apb(1'b1, `OCF_OFS_MCFG4, 32'h1);
    meas(0, 128);
    chk("no squelch main", 32'd64, 32'(hi));
    aref <= 1'b1;
    apb(1'b1, `OCF_OFS_OUTCFG4, 32'h0);
    meas(1, 64);
    chk("line off", 32'd0, 32'(hi));
    chk("line off oe", 32'h0, 32'(oe[1]));
    for (int k = 0; k < 2; k++) begin
      fr = (k == 1) ? 4096 : 1024;
      chk("fs oe off", 32'h0, 32'(oe[2+k]));
      apb(1'b1, `OCF_OFS_OUTCFG4, 32'(2 << k));
      apb(1'b1, `OCF_OFS_FSCFG1, '0);
      meas(2 + k, fr);
      chk("fs clock high", 32'(fr / 2), 32'(hi));
      chk("fs clock rises", 32'd1, 32'(rs));
      apb(1'b1, `OCF_OFS_FSCFG1, 32'(1 << (2 * k)));
      meas(2 + k, fr);
      chk("fs pulse low", 32'd4, 32'(fr - hi));
      apb(1'b1, `OCF_OFS_FSCFG1, 32'(3 << (2 * k)));
      meas(2 + k, fr);
      chk("fs pulse inverted", 32'd4, 32'(hi));
      chk("fs oe on", 32'h1, 32'(oe[2+k]));
    end
    results();
  end
endmodule : tb_ocf_clk_ctrl
`default_nettype wire
